// file: src/flash_security_mode_gate.sv
`timescale 1ns/10ps
`include "gate_map.svh"


module flash_security_mode_gate
	import gate_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic sealed_o,
	output logic full_access_flag_o,
	output logic loader_mode_o
);

	// Reset image: the gate wakes sealed with the full-access flag set.
	localparam gate_state_type GATE_RESET = '{
		waitreq: 1'b1,
		readdata: 32'h0,
		mode: MODE_SEALED,
		prior_sealed: 1'b1,
		blk_ctrl: `BLK_CTRL_FLASH,
		subclass: 8'h00,
		blk_sel: 8'h00,
		window: '0,
		tgt_valid: 1'b0,
		tgt_idx: 3'h0,
		sealed: 1'b1,
		full_access_flag: 1'b1,
		loader: 1'b0
	};

	gate_state_type s_reg; // Registered state.
	gate_state_type s_next; // Next state.

	logic req; // A bus request is present.
	logic wr_acc; // A write completes at this edge.
	logic lane0; // Byte lane 0 is enabled.
	logic win_hit; // Address falls in the command window.
	logic [4:0] byte_idx; // Window byte addressed.
	logic ctrl_wr; // Control word written at this edge.
	logic [15:0] ctrl_word; // Control word carried by the write.
	logic ck_wr; // Checksum written at this edge.
	logic ck_good; // Written checksum matches the window.
	logic load; // Subclass or block select written.
	logic [7:0] ctl_n; // Block access control after this edge.
	logic [7:0] sub_n; // Subclass after this edge.
	logic [7:0] sel_n; // Block select after this edge.
	logic [3:0] tgt; // Decoded target: valid flag and index.
	logic [255:0] store_rdata; // Block read from the store.
	logic store_we; // Commit the window into the store.
	logic [63:0] key_words; // Stored key words.
	logic unseal_ok; // Correct unseal pair completed.
	logic full_ok; // Correct full-access pair completed.
	logic key_word; // The control word is part of a key pair.
	logic [31:0] rd_mux; // Read data for the addressed register.

	// Eight-bit sum of the window bytes.
	function automatic logic [7:0] byte_sum(input logic [31:0][7:0] w);
		logic [7:0] acc;
		acc = 8'h00;
		for (int i = 0; i < 32; i++) begin
			acc = acc + w[i];
		end
		return acc;
	endfunction

	// Maps the addressing registers to a store block; bit 3 says it exists.
	function automatic logic [3:0] decode_target(input mode_type m, input logic [7:0] ctl,
		input logic [7:0] sub, input logic [7:0] sel);
		logic [3:0] t;
		t = 4'h0;
		if (m == MODE_LOADER) begin
			t = 4'h0;
		end else if (m == MODE_SEALED || ctl != `BLK_CTRL_FLASH) begin
			// Information blocks are picked by the block select alone.
			if (sel == `SEL_INFO_A) begin
				t = {1'b1, `IDX_INFO_A};
			end else if (sel == `SEL_INFO_B) begin
				t = {1'b1, `IDX_INFO_B};
			end else if (sel == `SEL_INFO_C) begin
				t = {1'b1, `IDX_INFO_C};
			end
		end else begin
			// Subclass addressing; the window byte index is the bus word offset modulo 32.
			case (sub)
				`SUB_CHG_INHIBIT: t = {1'b1, `IDX_CHG_INHIBIT};
				`SUB_CHARGE: t = {1'b1, `IDX_CHARGE};
				`SUB_CHG_TERM: t = {1'b1, `IDX_CHG_TERM};
				`SUB_MFG_INFO: t = {1'b1, `IDX_INFO_A};
				`SUB_PRIVATE: t = {1'b1, `IDX_PRIVATE};
				`SUB_KEYS: t = {1'b1, `IDX_KEYS};
				default: t = 4'h0;
			endcase
		end
		return t;
	endfunction

	// Private blocks are the scratch block and the key block.
	function automatic logic is_private(input logic [2:0] idx);
		return (idx == `IDX_PRIVATE) || (idx == `IDX_KEYS);
	endfunction

	// Read right of a mode over a block.
	function automatic logic can_read(input mode_type m, input logic [2:0] idx);
		logic ok;
		ok = 1'b0;
		unique case (m)
			MODE_SEALED: ok = !is_private(idx);
			MODE_UNSEALED: ok = 1'b1;
			MODE_FULL: ok = 1'b1;
			MODE_LOADER: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Write right of a mode over a block.
	function automatic logic can_write(input mode_type m, input logic [2:0] idx);
		logic ok;
		ok = 1'b0;
		unique case (m)
			// Only information blocks B and C may be edited while sealed.
			MODE_SEALED: ok = (idx == `IDX_INFO_B) || (idx == `IDX_INFO_C);
			// Unsealed lacks the right to write the stored keys.
			MODE_UNSEALED: ok = (idx != `IDX_KEYS);
			MODE_FULL: ok = 1'b1;
			MODE_LOADER: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Bus decode terms; a write acts only at the edge where waitrequest is low.
	assign req = avs_read_i | avs_write_i;
	assign wr_acc = avs_write_i & ~s_reg.waitreq;
	assign lane0 = avs_byteenable_i[0];
	assign win_hit = avs_address_i[`WINDOW_SEL_BIT];
	assign byte_idx = avs_address_i[6:2];
	assign ctrl_word = avs_writedata_i[15:0];
	assign ctrl_wr = wr_acc && (avs_address_i == `OFS_CONTROL) && (avs_byteenable_i[1:0] == 2'b11);
	assign ck_wr = wr_acc && (avs_address_i == `OFS_CHECKSUM) && lane0;
	assign ck_good = avs_writedata_i[7:0] == (`CHECKSUM_BASE - byte_sum(s_reg.window));
	assign load = wr_acc && lane0 && ((avs_address_i == `OFS_SUBCLASS) || (avs_address_i == `OFS_BLK_SEL));

	// Addressing registers as they stand after this edge, so a load sees the new value.
	assign ctl_n = (wr_acc && lane0 && avs_address_i == `OFS_BLK_CTRL) ? avs_writedata_i[7:0] : s_reg.blk_ctrl;
	assign sub_n = (wr_acc && lane0 && avs_address_i == `OFS_SUBCLASS) ? avs_writedata_i[7:0] : s_reg.subclass;
	assign sel_n = (wr_acc && lane0 && avs_address_i == `OFS_BLK_SEL) ? avs_writedata_i[7:0] : s_reg.blk_sel;
	assign tgt = decode_target(s_reg.mode, ctl_n, sub_n, sel_n);

	// Permission is checked against the mode at commit time, not at load time,
	// so a block loaded before sealing can no longer be written back.
	assign store_we = ck_wr && ck_good && s_reg.tgt_valid && can_write(s_reg.mode, s_reg.tgt_idx);

	// Flip-flop parameter store, keys included; reset reloads its image.
	param_store u_store (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rd_idx_i(tgt[2:0]),
		.rd_data_o(store_rdata),
		.we_i(store_we),
		.wr_idx_i(s_reg.tgt_idx),
		.wr_data_i(s_reg.window),
		.key_words_o(key_words)
	);

	// Key pair recogniser on the control word.
	key_pair_checker u_keys (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(ctrl_wr),
		.word_i(ctrl_word),
		.keys_i(key_words),
		.unseal_ok_o(unseal_ok),
		.full_ok_o(full_ok),
		.key_word_o(key_word)
	);

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_mux = 32'h0;
		if (win_hit) begin
			rd_mux[7:0] = s_reg.window[byte_idx];
		end else begin
			case (avs_address_i)
				`OFS_CONTROL: rd_mux[`STATUS_SEALED_BIT] = s_reg.sealed;
				`OFS_FLAGS: rd_mux[`FLAG_FULL_ACCESS_BIT] = s_reg.full_access_flag;
				`OFS_MODE: rd_mux[1:0] = s_reg.mode;
				`OFS_BLK_CTRL: rd_mux[7:0] = s_reg.blk_ctrl;
				`OFS_SUBCLASS: rd_mux[7:0] = s_reg.subclass;
				`OFS_BLK_SEL: rd_mux[7:0] = s_reg.blk_sel;
				`OFS_CHECKSUM: rd_mux[7:0] = `CHECKSUM_BASE - byte_sum(s_reg.window);
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// Next-state logic: bus handshake, window, mode machine and status bits.
	always_comb begin
		s_next = s_reg;
		// Every access takes two cycles: waitrequest drops for exactly one.
		s_next.waitreq = ~(req & s_reg.waitreq);
		if (req && s_reg.waitreq) begin
			s_next.readdata = rd_mux;
		end
		s_next.blk_ctrl = ctl_n;
		s_next.subclass = sub_n;
		s_next.blk_sel = sel_n;
		// The window itself is scratch space; protection applies at commit.
		if (wr_acc && win_hit && lane0) begin
			s_next.window[byte_idx] = avs_writedata_i[7:0];
		end
		// A block with no read right loads as zeros.
		if (load) begin
			s_next.tgt_valid = tgt[3];
			s_next.tgt_idx = tgt[2:0];
			s_next.window = (tgt[3] && can_read(s_reg.mode, tgt[2:0])) ? store_rdata : '0;
		end
		// Mode machine driven by control writes.
		if (ctrl_wr) begin
			if (unseal_ok && s_reg.mode == MODE_SEALED) begin
				s_next.mode = MODE_UNSEALED;
				s_next.prior_sealed = 1'b1;
			end else if (full_ok && s_reg.mode == MODE_UNSEALED) begin
				s_next.mode = MODE_FULL;
			end else if (!key_word) begin
				// Key words never reach the subcommand decoder; a misplaced pair skips it as well and is ignored.
				if (ctrl_word == `CMD_SEAL && (s_reg.mode == MODE_UNSEALED || s_reg.mode == MODE_FULL)) begin
					s_next.mode = MODE_SEALED;
					s_next.prior_sealed = 1'b1;
				end else if (ctrl_word == `CMD_RESET) begin
					if (s_reg.prior_sealed) begin
						s_next.mode = MODE_SEALED;
					end else if (s_reg.mode == MODE_LOADER) begin
						s_next.mode = MODE_UNSEALED;
					end
				end else if (ctrl_word == `CMD_LOADER && s_reg.mode == MODE_FULL) begin
					s_next.mode = MODE_LOADER;
				end
			end
		end
		// Dropping to a lower mode flushes the window so no private data lingers.
		if (s_next.mode != s_reg.mode && (s_next.mode == MODE_SEALED || s_next.mode == MODE_LOADER)) begin
			s_next.window = '0;
			s_next.tgt_valid = 1'b0;
		end
		// Status bits follow the mode; a wrong pair leaves the mode, so they hold too.
		s_next.sealed = s_next.mode == MODE_SEALED;
		s_next.full_access_flag = s_next.mode != MODE_FULL;
		s_next.loader = s_next.mode == MODE_LOADER;
	end

	// State register.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= GATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign avs_readdata_o = s_reg.readdata;
	assign avs_waitrequest_o = s_reg.waitreq;
	assign sealed_o = s_reg.sealed;
	assign full_access_flag_o = s_reg.full_access_flag;
	assign loader_mode_o = s_reg.loader;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Steps of a completed unseal and a completed full-access pair.
	sequence unseal_done;
		ctrl_wr && unseal_ok && s_reg.mode == MODE_SEALED;
	endsequence
	sequence full_done;
		ctrl_wr && full_ok && s_reg.mode == MODE_UNSEALED;
	endsequence

	AST_SEALED_A_READONLY: assert property (
		(s_reg.mode == MODE_SEALED && store_we) |-> s_reg.tgt_idx != `IDX_INFO_A)
		else $error("information block A written while sealed");
	AST_SEALED_ONLY_INFO: assert property (
		(s_reg.mode == MODE_SEALED && store_we) |-> (s_reg.tgt_idx == `IDX_INFO_B || s_reg.tgt_idx == `IDX_INFO_C))
		else $error("sealed commit reached a parameter block");
	AST_LOADER_NO_ACCESS: assert property (
		s_reg.loader |-> (!store_we && !(load && tgt[3])))
		else $error("parameter access in loader mode");
	AST_LOADER_FROM_FULL: assert property (
		$rose(loader_mode_o) |-> $past(s_reg.mode) == MODE_FULL)
		else $error("loader mode entered from a mode other than full access");
	AST_UNSEAL_CLEARS: assert property (
		unseal_done |=> (!sealed_o && s_reg.mode == MODE_UNSEALED) ##1 !sealed_o)
		else $error("sealed bit not cleared by unseal pair");
	AST_FULL_CLEARS_FLAG: assert property (
		full_done |=> !full_access_flag_o && s_reg.mode == MODE_FULL)
		else $error("full-access flag not cleared by full-access pair");
	AST_KEYS_FULL_ONLY: assert property (
		(store_we && s_reg.tgt_idx == `IDX_KEYS) |-> s_reg.mode == MODE_FULL)
		else $error("key block written outside full access");
	AST_RESET_RESEALS: assert property (
		(ctrl_wr && !key_word && ctrl_word == `CMD_RESET && s_reg.prior_sealed) |=> sealed_o)
		else $error("reset subcommand did not reseal");
	AST_INFO_SELECT: assert property (
		(load && s_reg.mode == MODE_SEALED && sel_n == `SEL_INFO_A) |=> s_reg.tgt_valid && s_reg.tgt_idx == `IDX_INFO_A)
		else $error("block select 1 did not pick information block A");
	AST_CHECKSUM_GATE: assert property (
		store_we |-> (avs_writedata_i[7:0] + byte_sum(s_reg.window)) == `CHECKSUM_BASE)
		else $error("block committed with a wrong checksum");
	AST_WRONG_PAIR_HOLDS: assert property (
		// A first key alone, a null word, or a whole pair sent from the wrong mode.
		(ctrl_wr && ((!unseal_ok && !full_ok && (key_word || ctrl_word == 16'h0000))
			|| (unseal_ok && !full_ok && s_reg.mode != MODE_SEALED)
			|| (full_ok && !unseal_ok && s_reg.mode != MODE_UNSEALED)))
		|=> $stable(s_reg.mode) && $stable(sealed_o) && $stable(full_access_flag_o))
		else $error("bad key word changed the security mode");
	AST_NO_RIGHT_DISCARD: assert property (
		(ck_wr && !can_write(s_reg.mode, s_reg.tgt_idx)) |-> !store_we)
		else $error("commit without write permission");

endmodule // flash_security_mode_gate

// file: pkg/gate_map.svh
`ifndef GATE_MAP_SVH
`define GATE_MAP_SVH

// Register byte offsets on the Avalon-MM slave.
`define OFS_CONTROL 8'h00
`define OFS_FLAGS 8'h04
`define OFS_MODE 8'h08
`define OFS_BLK_CTRL 8'h0c
`define OFS_SUBCLASS 8'h10
`define OFS_BLK_SEL 8'h14
`define OFS_CHECKSUM 8'h18
// Address bit that selects the 32-byte command window, one byte per word.
`define WINDOW_SEL_BIT 7

// Status bit positions.
`define STATUS_SEALED_BIT 0
`define FLAG_FULL_ACCESS_BIT 0

// Subclass identifiers that reach the parameter store.
`define SUB_CHG_INHIBIT 8'h20
`define SUB_CHARGE 8'h22
`define SUB_CHG_TERM 8'h24
`define SUB_MFG_INFO 8'h3a
`define SUB_PRIVATE 8'h68
`define SUB_KEYS 8'h70

// Store block indices.
`define IDX_CHG_INHIBIT 3'h0
`define IDX_CHARGE 3'h1
`define IDX_CHG_TERM 3'h2
`define IDX_PRIVATE 3'h3
`define IDX_KEYS 3'h4
`define IDX_INFO_A 3'h5
`define IDX_INFO_B 3'h6
`define IDX_INFO_C 3'h7

// Block select codes for the information blocks.
`define SEL_INFO_A 8'h01
`define SEL_INFO_B 8'h02
`define SEL_INFO_C 8'h03
// Block access control value that enables subclass addressing.
`define BLK_CTRL_FLASH 8'h00

// Control subcommands.
`define CMD_SEAL 16'h0020
`define CMD_RESET 16'h0041
`define CMD_LOADER 16'h0f00

// Keys as they read back from the store; the control word carries them byte-swapped.
`define KEY_UNSEAL0_RST 16'h1404
`define KEY_UNSEAL1_RST 16'h7236
`define KEY_FULL0_RST 16'hffff
`define KEY_FULL1_RST 16'hffff

// Checksum base: checksum equals this minus the byte sum of the window.
`define CHECKSUM_BASE 8'hff

`endif

// file: pkg/gate_pkg.sv
package gate_pkg;

	// Security modes of the gate.
	typedef enum logic [1:0] {
		MODE_SEALED,
		MODE_UNSEALED,
		MODE_FULL,
		MODE_LOADER
	} mode_type;

	// Whole state of the gate's top module.
	typedef struct packed {
		logic waitreq;
		logic [31:0] readdata;
		mode_type mode;
		logic prior_sealed;
		logic [7:0] blk_ctrl;
		logic [7:0] subclass;
		logic [7:0] blk_sel;
		logic [31:0][7:0] window;
		logic tgt_valid;
		logic [2:0] tgt_idx;
		logic sealed;
		logic full_access_flag;
		logic loader;
	} gate_state_type;

	// Arming state of the key pair checker.
	typedef struct packed {
		logic armed_unseal;
		logic armed_full;
	} key_state_type;

	// Parameter store: eight blocks of 32 bytes.
	typedef struct packed {
		logic [7:0][255:0] mem;
	} store_state_type;

endpackage

// file: src/param_store.sv
`timescale 1ns/10ps
`include "gate_map.svh"

module param_store
	import gate_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] rd_idx_i,
	output logic [255:0] rd_data_o,
	input wire logic we_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [255:0] wr_data_i,
	output logic [63:0] key_words_o
);

	// Key block image: four 16-bit keys in the lowest bytes, little-endian words.
	localparam logic [255:0] KEY_BLOCK_INIT = {192'h0, `KEY_FULL1_RST, `KEY_FULL0_RST,
		`KEY_UNSEAL1_RST, `KEY_UNSEAL0_RST};
	// Reset image of the whole store; only the key block is not blank.
	localparam logic [2047:0] STORE_RESET = 2048'(KEY_BLOCK_INIT) << (256 * `IDX_KEYS);

	store_state_type s_reg;
	store_state_type s_next;

	// A whole block is written at once, so a commit can never leave half a block.
	always_comb begin
		s_next = s_reg;
		if (we_i) begin
			s_next.mem[wr_idx_i] = wr_data_i;
		end
	end

	// Flip-flop storage; keys survive as the key block.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= STORE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rd_data_o = s_reg.mem[rd_idx_i];
	assign key_words_o = s_reg.mem[`IDX_KEYS][63:0];

endmodule // param_store

// file: src/key_pair_checker.sv
`timescale 1ns/10ps

module key_pair_checker
	import gate_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic [15:0] word_i,
	input wire logic [63:0] keys_i,
	output logic unseal_ok_o,
	output logic full_ok_o,
	output logic key_word_o
);

	key_state_type s_reg;
	key_state_type s_next;
	logic hit_unseal0;
	logic hit_full0;

	// Stored words read back byte-reversed from what the control word carries.
	function automatic logic [15:0] swap_bytes(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction

	assign hit_unseal0 = word_i == swap_bytes(keys_i[15:0]);
	assign hit_full0 = word_i == swap_bytes(keys_i[47:32]);
	assign unseal_ok_o = wr_i && s_reg.armed_unseal && (word_i == swap_bytes(keys_i[31:16]));
	assign full_ok_o = wr_i && s_reg.armed_full && (word_i == swap_bytes(keys_i[63:48]));
	assign key_word_o = hit_unseal0 | hit_full0 | unseal_ok_o | full_ok_o;

	// Every control write re-arms or voids, so a foreign word between keys breaks the pair.
	always_comb begin
		s_next = s_reg;
		if (wr_i) begin
			s_next.armed_unseal = hit_unseal0;
			s_next.armed_full = hit_full0;
		end
	end

	// Arming flags.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// An intervening word that is not the first unseal key leaves the unseal pair unarmed.
	AST_VOID_ON_OTHER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wr_i && !hit_unseal0) |=> !s_reg.armed_unseal)
		else $error("unseal sequence survived a foreign control word");

endmodule // key_pair_checker

// file: sim/gate_host.sv
`timescale 1ns/10ps

// Host master on the register bus, standing where the system controller of the gauge would be.
module gate_host (
	input wire logic clk_i,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i,
	output logic [7:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	output logic [3:0] avs_byteenable_o,
	output logic hung_o
);
	// The bus idles at time zero with every lane enabled.
	initial begin
		avs_address_o = 8'h00;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0;
		avs_byteenable_o = 4'hf;
		hung_o = 1'b0;
	end

	// One access; the request stands until waitrequest is seen low at a rising edge.
	// A bound on the wait keeps a dead slave from hanging the run.
	task automatic access(input logic is_wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_o <= addr;
		avs_read_o <= !is_wr;
		avs_write_o <= is_wr;
		avs_writedata_o <= wdata;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_i !== 1'b0 && n < 50);
		rdata = avs_readdata_i;
		// Only a wait that ended without an answer counts as a hang.
		if (avs_waitrequest_i !== 1'b0) begin
			hung_o <= 1'b1;
		end
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		// Released data lines show the inverse, never a stale copy.
		avs_writedata_o <= ~wdata;
	endtask

	// Byte lanes for the following accesses; only called between requests.
	task automatic set_lanes(input logic [3:0] be);
		avs_byteenable_o <= be;
	endtask
endmodule // gate_host

// file: sim/flash_security_mode_gate_bench.sv
`timescale 1ns/10ps
`include "gate_map.svh"

module flash_security_mode_gate_bench
	import gate_pkg::*;
;
	logic clk_i;
	logic rst_n_i;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sealed_o;
	logic full_access_flag_o;
	logic loader_mode_o;
	logic hung;
	int error_cnt = 0;
	int checks = 0;
	// Key block image: unseal pair, then the new full key0 and the old full key1.
	logic [7:0] kb [8] = '{8'h04, 8'h14, 8'h36, 8'h72, 8'h34, 8'h12, 8'hff, 8'hff};

	flash_security_mode_gate u_flash_security_mode_gate (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.avs_address_i(avs_address),
		.avs_read_i(avs_read),
		.avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata),
		.avs_byteenable_i(avs_byteenable),
		.avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest),
		.sealed_o(sealed_o),
		.full_access_flag_o(full_access_flag_o),
		.loader_mode_o(loader_mode_o)
	);

	gate_host u_host (
		.clk_i(clk_i),
		.avs_readdata_i(avs_readdata),
		.avs_waitrequest_i(avs_waitrequest),
		.avs_address_o(avs_address),
		.avs_read_o(avs_read),
		.avs_write_o(avs_write),
		.avs_writedata_o(avs_writedata),
		.avs_byteenable_o(avs_byteenable),
		.hung_o(hung)
	);

	// Free-running 200 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Prints the verdict and ends the run.
	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Compares a register value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	// Compares a status pin.
	task automatic chk_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: status pin %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		u_host.access(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		u_host.access(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	task automatic ctl(input logic [15:0] w);
		wr(`OFS_CONTROL, {16'h0, w});
	endtask

	task automatic put(input int n, input logic [7:0] v);
		wr(8'(8'h80 + 4 * n), {24'h0, v});
	endtask

	task automatic byte_is(input int n, input logic [7:0] e);
		rdc(8'(8'h80 + 4 * n), {24'h0, e});
	endtask

	// Mode register and all three status pins must agree with the expected mode.
	task automatic state_is(input mode_type m);
		rdc(`OFS_MODE, {30'h0, m});
		@(negedge clk_i);
		chk_pin(sealed_o, m == MODE_SEALED);
		chk_pin(full_access_flag_o, m != MODE_FULL);
		chk_pin(loader_mode_o, m == MODE_LOADER);
	endtask

	// A stuck slave counts as a mismatch and ends the run.
	always @(posedge clk_i) begin
		if (hung === 1'b1) begin
			error_cnt++;
			$display("ERROR %0t: bus access never completed", $time);
			report_and_stop();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		state_is(MODE_SEALED);
		rdc(`OFS_CONTROL, 32'h1);
		// Sealed: info A refuses a valid commit, info B takes one, a bad checksum is dropped.
		wr(`OFS_BLK_SEL, 32'h1);
		put(0, 8'h5a);
		wr(`OFS_CHECKSUM, 32'ha5);
		wr(`OFS_BLK_SEL, 32'h2);
		put(0, 8'h33);
		wr(`OFS_CHECKSUM, 32'hcc);
		wr(`OFS_BLK_SEL, 32'h1);
		byte_is(0, 8'h00);
		wr(`OFS_BLK_SEL, 32'h2);
		byte_is(0, 8'h33);
		wr(`OFS_BLK_SEL, 32'h3);
		put(0, 8'h11);
		wr(`OFS_CHECKSUM, 32'h00);
		wr(`OFS_BLK_SEL, 32'h3);
		byte_is(0, 8'h00);
		// Wrong, misplaced and interrupted key pairs change nothing.
		ctl(16'hffff);
		ctl(16'hffff);
		state_is(MODE_SEALED);
		ctl(16'h0414);
		ctl(16'h1234);
		state_is(MODE_SEALED);
		ctl(16'h0414);
		ctl(`CMD_SEAL);
		ctl(16'h3672);
		state_is(MODE_SEALED);
		// A non-control write between the keys does not void the pair.
		ctl(16'h0414);
		wr(`OFS_BLK_CTRL, {24'h0, `BLK_CTRL_FLASH});
		ctl(16'h3672);
		state_is(MODE_UNSEALED);
		ctl(`CMD_LOADER);
		state_is(MODE_UNSEALED);
		// A control write missing its upper lane is dropped, so this seal never takes.
		u_host.set_lanes(4'h1);
		ctl(`CMD_SEAL);
		u_host.set_lanes(4'hf);
		state_is(MODE_UNSEALED);
		// Unsealed: public, private and info A blocks are writable.
		wr(`OFS_SUBCLASS, {24'h0, `SUB_CHG_INHIBIT});
		put(0, 8'h2c);
		wr(`OFS_CHECKSUM, 32'hd3);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_CHG_INHIBIT});
		byte_is(0, 8'h2c);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_PRIVATE});
		put(0, 8'h77);
		wr(`OFS_CHECKSUM, 32'h88);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_PRIVATE});
		byte_is(0, 8'h77);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_MFG_INFO});
		put(0, 8'h42);
		wr(`OFS_CHECKSUM, 32'hbd);
		// Key change attempt outside full access is dropped.
		wr(`OFS_SUBCLASS, {24'h0, `SUB_KEYS});
		for (int i = 0; i < 8; i++) begin
			put(i, kb[i]);
		end
		wr(`OFS_CHECKSUM, 32'hfb);
		ctl(16'hffff);
		ctl(16'hffff);
		state_is(MODE_FULL);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_KEYS});
		byte_is(0, 8'h04);
		byte_is(1, 8'h14);
		byte_is(4, 8'hff);
		put(4, 8'h34);
		put(5, 8'h12);
		wr(`OFS_CHECKSUM, 32'hfb);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_KEYS});
		byte_is(4, 8'h34);
		ctl(`CMD_SEAL);
		state_is(MODE_SEALED);
		wr(`OFS_BLK_SEL, 32'h1);
		byte_is(0, 8'h42);
		ctl(16'h0414);
		ctl(16'h3672);
		state_is(MODE_UNSEALED);
		// The old full pair is dead; the new one goes in byte-swapped.
		ctl(16'hffff);
		ctl(16'hffff);
		state_is(MODE_UNSEALED);
		ctl(16'h3412);
		ctl(16'hffff);
		state_is(MODE_FULL);
		ctl(`CMD_LOADER);
		state_is(MODE_LOADER);
		wr(`OFS_SUBCLASS, {24'h0, `SUB_CHG_INHIBIT});
		byte_is(0, 8'h00);
		ctl(`CMD_RESET);
		state_is(MODE_SEALED);
		rdc(8'h40, 32'h0);
		report_and_stop();
	end
endmodule // flash_security_mode_gate_bench
